// ---- rti_regs.svh ----
// register offsets, field positions, reset values and timing figures of the reserve timer block
`ifndef RTI_REGS_SVH
`define RTI_REGS_SVH

// register pointer values
`define RTI_ADDR_CTRL      3'h2
`define RTI_ADDR_RESERVE   3'h3
`define RTI_ADDR_FLAGS     3'h4
`define RTI_ADDR_MASK      3'h5

// field positions in the flag and mask registers
`define RTI_BIT_INT_IN     0
`define RTI_BIT_LOST       1
`define RTI_BIT_GRANT      2
`define RTI_BIT_SELF       3
`define RTI_BIT_TAKEN      4
`define RTI_BIT_MAIL       5
`define RTI_BIT_HUNG       6

// self-interrupt trigger bit in the control register
`define RTI_BIT_SELF_TRIG  5

// reset values and the used flag bits
`define RTI_RESERVE_RST    8'h00
`define RTI_FLAGS_RST      8'h00
`define RTI_MASK_RST       8'h7F
`define RTI_FLAGS_USED     8'h7F

// timing figures
`define RTI_CLK_PERIOD_NS  5
`define RTI_MS_NS          1_000_000
`define RTI_HUNG_MS        500

`endif

// ---- rti_pkg.sv ----
// types shared by the reserve timer and event flag block
package rti_pkg;

  // one register access from an upstream master
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } rti_req_t;

  // downstream bus line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } rti_bus_t;

  // reserve countdown state per master
  typedef enum logic [1:0] {
    RTI_IDLE    = 2'b00,
    RTI_RUN     = 2'b01,
    RTI_EXPIRED = 2'b10,
    RTI_HOLD    = 2'b11
  } rti_timer_t;

endpackage

// ---- rti_core.sv ----
// reserve countdown and sticky event flags for two upstream masters
//
// Contract
// R1: reserve writes ignored while this master owns
// R2: reserve is 8 bits, one millisecond per count
// R3: zero reserve disables the countdown entirely
// R4: zero reserve holds until request is dropped
// R5: every flag sticky until written with one
// R6: hung downstream bus flags both masters
// R7: new incoming mail sets bit five
// R8: outgoing mail taken sets bit four
// R9: self trigger write sets bit three
// R10: ownership granted sets bit two
// R11: involuntary ownership loss sets bit one
// R12: downstream interrupt sets bit zero, both masters
// R13: expired countdown plus free bus clears grant
// R14: mask bit one suppresses, resets to 7Fh
// R15: interrupt low while unmasked flag set
// R16: per-master copies, own accesses only
`timescale 1ns/100ps
`default_nettype none
`include "rti_regs.svh"

module rti_core
  import rti_pkg::*;
#(
  parameter int MS_CYCLES = `RTI_MS_NS / `RTI_CLK_PERIOD_NS  // clock cycles per millisecond
) (
  // clocks, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       link_clk_i,
  // register access, one port per master
  input  wire rti_req_t   req_i [2],
  output logic [7:0]      rdata_o [2],
  // arbiter side, same clock
  input  wire logic [1:0] lock_req_i,
  input  wire logic [1:0] lock_grant_i,
  input  wire logic [1:0] mail_in_evt_i,
  input  wire logic [1:0] mail_taken_evt_i,
  output logic [1:0]      grant_clear_o,
  // downstream pins
  input  wire rti_bus_t   bus_i,
  input  wire logic       int_in_n_i,
  // upstream interrupt pins
  output logic [1:0]      irq_n_o
);

  localparam logic [9:0] HUNG_TICKS = 10'(`RTI_HUNG_MS);  // ms ticks for hung bus

  // ------------------------------------------------------------------
  // link domain: stop condition detect on the link clock
  // ------------------------------------------------------------------
  logic [1:0] lrst_sync;   // reset carried into the link domain
  logic       lrst;        // link domain reset
  rti_bus_t   lbus_s1;     // first stage, read only by second
  rti_bus_t   lbus_s2;     // synchronised levels
  rti_bus_t   lbus_d;      // previous levels for edge detect
  logic       stop_tgl;    // toggles on each stop condition

  // reset bridge; no reset on these flops by design
  always_ff @(posedge link_clk_i) begin
    lrst_sync <= {lrst_sync[0], rst_i};
  end
  assign lrst = lrst_sync[1];

  // two-flop synchroniser for the bus lines
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      lbus_s1 <= '{scl: 1'b1, sda: 1'b1};
      lbus_s2 <= '{scl: 1'b1, sda: 1'b1};
      lbus_d  <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      lbus_s1 <= bus_i;
      lbus_s2 <= lbus_s1;
      lbus_d  <= lbus_s2;
    end
  end

  // stop is sda rising while scl high; passed over as a toggle
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      stop_tgl <= 1'b0;
    end else if (lbus_s2.scl && lbus_d.scl && lbus_s2.sda && !lbus_d.sda) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // ------------------------------------------------------------------
  // main domain: crossings and pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] stop_sync;   // toggle synchroniser plus edge stage
  logic       stop_evt;    // one cycle per stop
  rti_bus_t   bus_s1;      // first stage, read only by second
  rti_bus_t   bus_s2;      // synchronised bus levels
  rti_bus_t   bus_d;       // previous levels for scl edge
  logic [1:0] int_sync;    // downstream interrupt synchroniser

  // crossings; held with the rest of the main domain while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_sync <= 3'h0;
      bus_s1    <= '{scl: 1'b1, sda: 1'b1};
      bus_s2    <= '{scl: 1'b1, sda: 1'b1};
      bus_d     <= '{scl: 1'b1, sda: 1'b1};
      int_sync  <= 2'h3;
    end else if (ce_i) begin
      stop_sync <= {stop_sync[1:0], stop_tgl};
      bus_s1    <= bus_i;
      bus_s2    <= bus_s1;
      bus_d     <= bus_s2;
      int_sync  <= {int_sync[0], int_in_n_i};
    end
  end
  assign stop_evt = stop_sync[2] ^ stop_sync[1];

  // ------------------------------------------------------------------
  // millisecond tick shared by reserve and hung timing
  // ------------------------------------------------------------------
  logic [31:0] ms_cnt;     // cycles within the current millisecond
  logic        ms_tick;    // one cycle per millisecond

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_cnt  <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end else if (ce_i) begin
      ms_tick <= (ms_cnt == 32'(MS_CYCLES - 1));
      if (ms_cnt == 32'(MS_CYCLES - 1)) begin
        ms_cnt <= 32'h0000_0000;
      end else begin
        ms_cnt <= ms_cnt + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // hung bus watch
  // ------------------------------------------------------------------
  logic [9:0] sda_low_ms;  // ms with sda low and scl still
  logic [9:0] scl_low_ms;  // ms with scl low
  logic       hung_evt;    // one cycle when a hang is first seen

  // counters saturate so one hang raises one event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_low_ms <= 10'h000;
      scl_low_ms <= 10'h000;
      hung_evt   <= 1'b0;
    end else if (ce_i) begin
      hung_evt <= 1'b0;
      // strictly more than the limit with sda low and no scl edge
      if (bus_s2.sda || (bus_s2.scl != bus_d.scl)) begin
        sda_low_ms <= 10'h000;
      end else if (ms_tick && sda_low_ms <= HUNG_TICKS) begin
        sda_low_ms <= sda_low_ms + 10'h001;
        if (sda_low_ms == HUNG_TICKS) begin
          hung_evt <= 1'b1;  // R6
        end
      end
      // scl low for the full limit
      if (bus_s2.scl) begin
        scl_low_ms <= 10'h000;
      end else if (ms_tick && scl_low_ms < HUNG_TICKS) begin
        scl_low_ms <= scl_low_ms + 10'h001;
        if (scl_low_ms == HUNG_TICKS - 10'h001) begin
          hung_evt <= 1'b1;  // R6
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // per-master register file
  // ------------------------------------------------------------------
  logic [7:0] reserve [2];  // reserve duration per master
  logic [7:0] mask    [2];  // event mask per master
  logic [7:0] flags   [2];  // sticky event flags per master

  // decode a write to one register
  function automatic logic wr_hit(input rti_req_t r, input logic [2:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // reserve duration store; a master only reaches its own copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int m = 0; m < 2; m++) begin
        reserve[m] <= `RTI_RESERVE_RST;
      end
    end else if (ce_i) begin
      for (int m = 0; m < 2; m++) begin
        // writes while owning are dropped, not deferred
        if (wr_hit(req_i[m], `RTI_ADDR_RESERVE) && !lock_grant_i[m]) begin  // R1
          reserve[m] <= req_i[m].wdata;  // R2 R16
        end
      end
    end
  end

  // mask store; reset value leaves every event masked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int m = 0; m < 2; m++) begin
        mask[m] <= `RTI_MASK_RST;  // R14
      end
    end else if (ce_i) begin
      for (int m = 0; m < 2; m++) begin
        if (wr_hit(req_i[m], `RTI_ADDR_MASK)) begin
          mask[m] <= req_i[m].wdata & `RTI_FLAGS_USED;  // R14
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // reserve countdown per master
  // ------------------------------------------------------------------
  rti_timer_t tstate   [2];  // countdown state
  logic [8:0] tcount   [2];  // remaining milliseconds, one spare count
  logic [1:0] stop_seen;     // stop observed since grant
  logic [1:0] grant_d;       // grant one cycle ago

  // grant edge marks start; a zero duration never expires
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int m = 0; m < 2; m++) begin
        tstate[m] <= RTI_IDLE;
        tcount[m] <= 9'h000;
      end
      stop_seen     <= 2'b00;
      grant_d       <= 2'b00;
      grant_clear_o <= 2'b00;
    end else if (ce_i) begin
      grant_d <= lock_grant_i;
      for (int m = 0; m < 2; m++) begin
        grant_clear_o[m] <= 1'b0;
        if (lock_grant_i[m] && !grant_d[m]) begin
          stop_seen[m] <= 1'b0;
        end else if (stop_evt) begin
          stop_seen[m] <= 1'b1;
        end
        unique case (tstate[m])
          RTI_IDLE: begin
            if (lock_grant_i[m] && !grant_d[m]) begin
              // spare count: the shared ms tick may fall at once, never cut short
              tcount[m] <= {1'h0, reserve[m]} + 9'h001;  // R2
              // zero duration: hold with no limit
              tstate[m] <= (reserve[m] == 8'h00) ? RTI_HOLD : RTI_RUN;  // R3
            end
          end
          RTI_RUN: begin
            if (!lock_grant_i[m]) begin
              tstate[m] <= RTI_IDLE;
            end else if (tcount[m] == 9'h000) begin
              tstate[m] <= RTI_EXPIRED;
            end else if (ms_tick) begin
              tcount[m] <= tcount[m] - 9'h001;  // R2
            end
          end
          RTI_EXPIRED: begin
            // release only once the bus is free after a stop
            if (!lock_grant_i[m]) begin
              tstate[m] <= RTI_IDLE;
            end else if (stop_seen[m] && bus_s2.scl && bus_s2.sda) begin
              grant_clear_o[m] <= 1'b1;  // R13
            end
          end
          RTI_HOLD: begin
            // only a dropped grant ends this hold, whether the request fell or it was taken
            if (!lock_grant_i[m]) begin
              tstate[m] <= RTI_IDLE;  // R4
            end
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // sticky event flags
  // ------------------------------------------------------------------
  // events of one master in flag-bit positions
  function automatic logic [7:0] events(input int m);
    logic [7:0] e;
    e = 8'h00;
    e[`RTI_BIT_HUNG]  = hung_evt;  // R6
    e[`RTI_BIT_MAIL]  = mail_in_evt_i[m];  // R7
    e[`RTI_BIT_TAKEN] = mail_taken_evt_i[m];  // R8
    e[`RTI_BIT_SELF]  = req_i[m].wr && (req_i[m].addr == `RTI_ADDR_CTRL)
                        && req_i[m].wdata[`RTI_BIT_SELF_TRIG];  // R9
    e[`RTI_BIT_GRANT] = lock_grant_i[m] && !grant_d[m];  // R10
    // loss with request still up and timer not run out
    e[`RTI_BIT_LOST]  = !lock_grant_i[m] && grant_d[m] && lock_req_i[m]
                        && (tstate[m] != RTI_EXPIRED);  // R11
    e[`RTI_BIT_INT_IN] = !int_sync[1];  // R12
    return e;
  endfunction

  // write-one-clear pattern carried by one access
  function automatic logic [7:0] clr_mask(input rti_req_t r);
    return wr_hit(r, `RTI_ADDR_FLAGS) ? r.wdata : 8'h00;
  endfunction

  // set wins over a same-cycle write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int m = 0; m < 2; m++) begin
        flags[m] <= `RTI_FLAGS_RST;
      end
    end else if (ce_i) begin
      for (int m = 0; m < 2; m++) begin
        // hung and int_in reach both copies; the rest stay local
        flags[m] <= ((flags[m] & ~clr_mask(req_i[m])) | events(m)) & `RTI_FLAGS_USED;  // R5 R16
      end
    end
  end

  // ------------------------------------------------------------------
  // read data and interrupt pins
  // ------------------------------------------------------------------
  // read answer registered one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int m = 0; m < 2; m++) begin
        rdata_o[m] <= 8'h00;
      end
    end else if (ce_i) begin
      for (int m = 0; m < 2; m++) begin
        if (req_i[m].rd) begin
          unique case (req_i[m].addr)
            `RTI_ADDR_RESERVE: rdata_o[m] <= reserve[m];
            `RTI_ADDR_FLAGS:   rdata_o[m] <= flags[m];
            `RTI_ADDR_MASK:    rdata_o[m] <= mask[m];
            default:           rdata_o[m] <= 8'h00;  // not held here
          endcase
        end
      end
    end
  end

  // active-low interrupt, low while any unmasked flag stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_n_o <= 2'b11;
    end else if (ce_i) begin
      for (int m = 0; m < 2; m++) begin
        irq_n_o[m] <= ~|(flags[m] & ~mask[m]);  // R14 R15
      end
    end
  end

endmodule

`default_nettype wire

// ---- rti_core_props.sv ----
// assertions on the reserve timer and event flag ports
`timescale 1ns/100ps
`default_nettype none
module rti_core_props
  import rti_pkg::*;
#(
  parameter int MS_CYCLES = 20
) (
  // clocks, reset, enable
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       link_clk_i,
  // register ports
  input wire rti_req_t   req_i [2],
  input wire logic [7:0] rdata_o [2],
  // arbiter side
  input wire logic [1:0] lock_req_i,
  input wire logic [1:0] lock_grant_i,
  input wire logic [1:0] mail_in_evt_i,
  input wire logic [1:0] mail_taken_evt_i,
  input wire logic [1:0] grant_clear_o,
  // pins
  input wire rti_bus_t   bus_i,
  input wire logic       int_in_n_i,
  input wire logic [1:0] irq_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] mask_q [2]; // shadow of each mask
  logic [1:0] mask_seen;  // mask written since reset
  // mirror mask writes so irq checks know what is enabled
  always_ff @(posedge clk_i) begin
    for (int m = 0; m < 2; m++) begin
      if (rst_i) begin
        mask_q[m] <= 8'h7F;
        mask_seen[m] <= 1'h0;
      end else if (ce_i && req_i[m].wr && req_i[m].addr == 3'h5) begin
        mask_q[m] <= req_i[m].wdata;
        mask_seen[m] <= 1'h1;
      end
    end
  end
  logic [7:0] res_q [2]; // reserve as it should read back
  // reserve shadow; a write under grant must not land
  always_ff @(posedge clk_i) begin
    for (int m = 0; m < 2; m++) begin
      if (rst_i) begin
        res_q[m] <= 8'h00;
      end else if (ce_i && req_i[m].wr && req_i[m].addr == 3'h3 && !lock_grant_i[m]) begin
        res_q[m] <= req_i[m].wdata;
      end
    end
  end
  a_reserve_lock: assert property (ce_i && req_i[0].rd && req_i[0].addr == 3'h3
    |=> rdata_o[0] == $past(res_q[0]))
    else $error("reserve changed while owning");
  a_rdata_hold0: assert property (!req_i[0].rd |=> $stable(rdata_o[0]))
    else $error("read data of port 0 moved without a read");
  a_rdata_hold1: assert property (!req_i[1].rd |=> $stable(rdata_o[1]))
    else $error("read data of port 1 moved without a read");
  a_unmapped_zero: assert property (ce_i && req_i[0].rd
    && req_i[0].addr inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7} |=> rdata_o[0] == 8'h00)
    else $error("unmapped read not zero");
  a_bit7_zero: assert property (ce_i && req_i[0].rd
    && req_i[0].addr inside {3'h4, 3'h5} |=> !rdata_o[0][7])
    else $error("reserved bit read as one");
  a_mask_default: assert property ((irq_n_o | mask_seen) == 2'h3)
    else $error("interrupt before any mask write");
  a_clear_grant: assert property (grant_clear_o[0] |-> $past(lock_grant_i[0]))
    else $error("grant clear without grant");
  a_self_irq: assert property (ce_i && req_i[0].wr && req_i[0].addr == 3'h2
    && req_i[0].wdata[5] && !mask_q[0][3] |-> ##[1:4] !irq_n_o[0])
    else $error("self trigger gave no interrupt");
  a_grant_irq: assert property ($rose(lock_grant_i[0]) && !mask_q[0][2]
    |-> ##[1:4] !irq_n_o[0])
    else $error("grant gave no interrupt");
  a_int_in_irq: assert property (!int_in_n_i && !mask_q[1][0]
    |-> ##[1:8] !irq_n_o[1])
    else $error("downstream interrupt not passed on");
  c_clear: cover property (grant_clear_o[0]);
  c_loss: cover property ($fell(lock_grant_i[0]) && lock_req_i[0]);
  c_both_irq: cover property (irq_n_o == 2'h0);
endmodule
bind rti_core rti_core_props #(.MS_CYCLES(MS_CYCLES)) rti_core_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .link_clk_i(link_clk_i),
  .req_i(req_i), .rdata_o(rdata_o), .lock_req_i(lock_req_i),
  .lock_grant_i(lock_grant_i), .mail_in_evt_i(mail_in_evt_i),
  .mail_taken_evt_i(mail_taken_evt_i), .grant_clear_o(grant_clear_o),
  .bus_i(bus_i), .int_in_n_i(int_in_n_i), .irq_n_o(irq_n_o));
`default_nettype wire

// ---- rti_arb_model.sv ----
// arbiter model granting ownership from request levels
`timescale 1ns/100ps
`default_nettype none
module rti_arb_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // request, release and forced loss
  input  wire logic [1:0] lock_req_i,
  input  wire logic [1:0] grant_clear_i,
  input  wire logic [1:0] steal_i,
  // ownership
  output logic [1:0]      lock_grant_o
);
  logic [1:0] spent; // cleared owner, no regrant until request drops
  // master 0 wins a tie; a regrant after expiry would reload the timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_grant_o <= 2'h0;
      spent <= 2'h0;
    end else begin
      spent <= (spent | grant_clear_i) & lock_req_i;
      lock_grant_o[0] <= lock_req_i[0] & ~spent[0] & ~grant_clear_i[0]
        & ~steal_i[0] & ~lock_grant_o[1];
      lock_grant_o[1] <= lock_req_i[1] & ~spent[1] & ~grant_clear_i[1]
        & ~steal_i[1] & ~lock_grant_o[0] & (lock_grant_o[1] | ~lock_req_i[0]);
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// testbench for the reserve timer and event flag block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import rti_pkg::*;
;
  localparam int MS = 20; // cycles per ms, short for sim
  typedef struct packed {
    logic       we;
    logic       m;
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } rti_row_t;
  logic       clk = 1'h0;
  logic       lclk = 1'h0;
  logic       rst = 1'h1;
  logic       ce = 1'h1;
  rti_req_t   req [2] = '{default: '0};
  logic [7:0] rdata [2];
  logic [1:0] lreq = 2'h0;
  logic [1:0] grant;
  logic [1:0] mail_in = 2'h0;
  logic [1:0] mail_tk = 2'h0;
  logic [1:0] gclr;
  logic [1:0] steal = 2'h0;
  rti_bus_t   bus = '{scl: 1'h1, sda: 1'h1};
  logic       int_n = 1'h1;
  logic [1:0] irq_n;
  int         err_count = 0;
  int         checked = 0;
  int         cyc = 0;
  int         n;
  // plain cases: optional write, then read back
  rti_row_t rows [11] = '{
    '{1'h0, 1'h0, 3'h3, 8'h00, 8'h00}, '{1'h0, 1'h1, 3'h4, 8'h00, 8'h00},
    '{1'h0, 1'h0, 3'h5, 8'h00, 8'h7F}, '{1'h1, 1'h0, 3'h3, 8'h5A, 8'h5A},
    '{1'h1, 1'h1, 3'h3, 8'hA5, 8'hA5}, '{1'h0, 1'h0, 3'h3, 8'h00, 8'h5A},
    '{1'h1, 1'h0, 3'h6, 8'hFF, 8'h00}, '{1'h1, 1'h1, 3'h3, 8'hFF, 8'hFF},
    '{1'h1, 1'h1, 3'h5, 8'hFF, 8'h7F}, '{1'h1, 1'h0, 3'h5, 8'h00, 8'h00},
    '{1'h1, 1'h1, 3'h5, 8'h00, 8'h00}};
  always #2.5 clk = ~clk;
  always #3 lclk = ~lclk;
  rti_core #(.MS_CYCLES(MS)) rti_core_i (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .link_clk_i(lclk), .req_i(req),
    .rdata_o(rdata), .lock_req_i(lreq), .lock_grant_i(grant), .mail_in_evt_i(mail_in),
    .mail_taken_evt_i(mail_tk), .grant_clear_o(gclr), .bus_i(bus),
    .int_in_n_i(int_n), .irq_n_o(irq_n));
  rti_arb_model rti_arb_model_i (
    .clk_i(clk), .rst_i(rst), .lock_req_i(lreq), .grant_clear_i(gclr),
    .steal_i(steal), .lock_grant_o(grant));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one-cycle strobe, then a spare cycle so effects settle
  task automatic acc(input logic w, input logic m, input logic [2:0] a, input logic [7:0] d);
    req[m] = '{w, ~w, a, d};
    tick(1);
    req[m] = '0;
    tick(1);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic rd(input logic m, input logic [2:0] a, input logic [7:0] e);
    acc(1'h0, m, a, 8'h00);
    chk(rdata[m], e);
  endtask
  task automatic wrap_up();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard, ceiling well above the two hung-bus waits
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    tick(5);
    rst = 1'h0;
    foreach (rows[i]) begin
      if (rows[i].we) acc(1'h1, rows[i].m, rows[i].a, rows[i].d);
      rd(rows[i].m, rows[i].a, rows[i].e);
    end
    $display("test rows done");
    acc(1'h1, 1'h0, 3'h2, 8'h20);
    rd(1'h0, 3'h4, 8'h08);
    rd(1'h1, 3'h4, 8'h00);
    chk({7'h00, irq_n[0]}, 8'h00);
    acc(1'h1, 1'h0, 3'h4, 8'hF7);
    rd(1'h0, 3'h4, 8'h08);
    acc(1'h1, 1'h0, 3'h4, 8'h08);
    rd(1'h0, 3'h4, 8'h00);
    chk({6'h00, irq_n}, 8'h03);
    $display("test self done");
    mail_in = 2'h2;
    tick(1);
    mail_in = 2'h0;
    mail_tk = 2'h2;
    tick(1);
    mail_tk = 2'h0;
    rd(1'h1, 3'h4, 8'h30);
    rd(1'h0, 3'h4, 8'h00);
    acc(1'h1, 1'h1, 3'h4, 8'hFF);
    $display("test mail done");
    acc(1'h1, 1'h0, 3'h3, 8'h00);
    lreq = 2'h1;
    tick(3);
    acc(1'h1, 1'h0, 3'h3, 8'h11);
    rd(1'h0, 3'h3, 8'h00);
    tick(300);
    chk({6'h00, grant}, 8'h01);
    lreq = 2'h0;
    tick(3);
    rd(1'h0, 3'h4, 8'h04);
    acc(1'h1, 1'h0, 3'h4, 8'hFF);
    $display("test hold done");
    acc(1'h1, 1'h0, 3'h3, 8'h01);
    lreq = 2'h1;
    tick(5);
    bus.sda = 1'h0;
    tick(10);
    bus.scl = 1'h0;
    tick(10);
    bus.scl = 1'h1;
    tick(10);
    bus.sda = 1'h1;
    n = 0;
    while (grant[0] !== 1'h0 && n < 200) begin
      tick(1);
      n++;
    end
    chk({6'h00, grant}, 8'h00);
    lreq = 2'h0;
    tick(3);
    rd(1'h0, 3'h4, 8'h04);
    acc(1'h1, 1'h0, 3'h4, 8'hFF);
    $display("test expiry done");
    acc(1'h1, 1'h0, 3'h3, 8'h00);
    lreq = 2'h1;
    tick(3);
    steal = 2'h1;
    tick(3);
    lreq = 2'h0;
    steal = 2'h0;
    tick(3);
    rd(1'h0, 3'h4, 8'h06);
    acc(1'h1, 1'h0, 3'h4, 8'hFF);
    $display("test loss done");
    int_n = 1'h0;
    tick(10);
    int_n = 1'h1;
    tick(4);
    rd(1'h0, 3'h4, 8'h01);
    rd(1'h1, 3'h4, 8'h01);
    acc(1'h1, 1'h0, 3'h4, 8'hFF);
    acc(1'h1, 1'h1, 3'h4, 8'hFF);
    $display("test int_in done");
    bus.sda = 1'h0;
    tick(MS * 500 + 300);
    rd(1'h0, 3'h4, 8'h40);
    rd(1'h1, 3'h4, 8'h40);
    bus.sda = 1'h1;
    acc(1'h1, 1'h0, 3'h4, 8'hFF);
    acc(1'h1, 1'h1, 3'h4, 8'hFF);
    // scl held low is the other kind of hang
    bus.scl = 1'h0;
    tick(MS * 500 + 300);
    rd(1'h0, 3'h4, 8'h40);
    rd(1'h1, 3'h4, 8'h40);
    bus.scl = 1'h1;
    $display("test hung done");
    // enable low: a write must not land
    ce = 1'h0;
    acc(1'h1, 1'h1, 3'h3, 8'h33);
    ce = 1'h1;
    rd(1'h1, 3'h3, 8'hFF);
    $display("test enable done");
    // second reset in mid-run brings back every reset value
    rst = 1'h1;
    tick(5);
    rst = 1'h0;
    rd(1'h1, 3'h3, 8'h00);
    rd(1'h0, 3'h4, 8'h00);
    rd(1'h1, 3'h5, 8'h7F);
    chk({6'h00, irq_n}, 8'h03);
    chk({6'h00, grant}, 8'h00);
    chk({6'h00, gclr}, 8'h00);
    $display("test reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
